// File: axi_lite_port.v
// AXI4-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
`include "i2c_clear_bank_defines.vh"

module axi_lite_port (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // Write address and data
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] awaddr,
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  // Write response
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  // Read address and data
  input  wire        arvalid,
  output reg         arready,
  input  wire [31:0] araddr,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  // Register side strobes
  output reg         regRd,
  output reg  [31:0] regRdAddr,
  input  wire [31:0] regRdData,
  input  wire        regRdErr,
  output reg         regWr,
  output reg  [31:0] regWrAddr,
  output reg  [31:0] regWrData,
  output reg  [3:0]  regWrStrb,
  input  wire        regWrErr
);

  reg awHave;
  reg wHave;

  // Read path: one read in flight, strobe one cycle after address taken
  always @(posedge clock) begin
    if (!rst_n) begin
      arready   <= 1'b1;
      regRd     <= 1'b0;
      regRdAddr <= 32'h00000000;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= `RESP_OKAY;
    end else begin
      regRd <= 1'b0;
      if (arvalid && arready) begin
        arready   <= 1'b0;
        regRdAddr <= araddr;
        regRd     <= 1'b1;
      end
      if (regRd) begin
        rvalid <= 1'b1;
        rdata  <= regRdData;
        rresp  <= regRdErr ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Write path: address and data in either order, then one strobe
  always @(posedge clock) begin
    if (!rst_n) begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      awHave    <= 1'b0;
      wHave     <= 1'b0;
      regWr     <= 1'b0;
      regWrAddr <= 32'h00000000;
      regWrData <= 32'h00000000;
      regWrStrb <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
    end else begin
      regWr <= 1'b0;
      if (awvalid && awready) begin
        awready   <= 1'b0;
        awHave    <= 1'b1;
        regWrAddr <= awaddr;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        wHave     <= 1'b1;
        regWrData <= wdata;
        regWrStrb <= wstrb;
      end
      if (awHave && wHave && !regWr && !bvalid) begin
        regWr <= 1'b1;
      end
      if (regWr) begin
        bvalid <= 1'b1;
        bresp  <= regWrErr ? `RESP_SLVERR : `RESP_OKAY;
        awHave <= 1'b0;
        wHave  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

endmodule // axi_lite_port

// File: i2c_clear_bank_defines.vh
// Register map, field positions, reset values and bus answers of the flag clear bank
// Overview of operation
// (RQ1) Reading rx-overflow clear register clears raw status bit 1.
// (RQ2) Reading tx-overflow clear register clears raw status bit 3.
// (RQ3) Reading read-request clear register clears raw status bit 5.
// (RQ4) Reading tx-abort clear register clears bit 6 and the abort source register.
// (RQ5) Reading tx-abort clear register releases the transmit FIFO from flush/hold.
// (RQ6) Abort source bit 9 is kept when abort state is cleared by a read.
// (RQ7) Reading rx-done clear register clears raw status bit 7.
// (RQ8) Reading activity clear register clears activity flag only when bus is idle.
// (RQ9) While the bus is still active the activity flag stays set.
// (RQ10) Activity flag clears itself when disabled and bus is idle.
// (RQ11) Activity clear register reads back the activity flag, raw bit 8.
// (RQ12) Reading start-detect clear register clears raw status bit 10.
// (RQ13) Reading general-call clear register clears raw status bit 11.
// (RQ14) Combined clear read clears all software flags and abort source register.
// (RQ15) Reading rx-underflow clear register clears raw status bit 0.
// (RQ16) Disabling the controller flushes both transmit and receive FIFOs.
// (RQ17) Reading stop-detect clear register clears the stop-condition flag.
// (RQ18) Clear registers read zero in bits 15:1, clear on read, ignore writes.
`ifndef I2C_CLEAR_BANK_DEFINES_VH
`define I2C_CLEAR_BANK_DEFINES_VH

// Byte addresses of the registers
`define ADDR_COMBINED_CLR   32'h50001340
`define ADDR_RX_UNDER_CLR   32'h50001344
`define ADDR_RX_OVER_CLR    32'h50001348
`define ADDR_TX_OVER_CLR    32'h5000134c
`define ADDR_RD_REQ_CLR     32'h50001350
`define ADDR_TX_ABORT_CLR   32'h50001354
`define ADDR_RX_DONE_CLR    32'h50001358
`define ADDR_ACTIVITY_CLR   32'h5000135c
`define ADDR_STOP_CONDITION_FLAG_CLR   32'h50001360
`define ADDR_START_CONDITION_FLAG_CLR  32'h50001364
`define ADDR_GEN_CALL_CLR   32'h50001368
`define ADDR_ON_OFF         32'h5000136c
`define ADDR_ABORT_SOURCE   32'h50001380
`define ADDR_RAW_STATUS     32'h500013f0

// Raw interrupt status bit positions
`define BIT_RX_UNDER        0
`define BIT_RX_OVER         1
`define BIT_RX_FULL         2
`define BIT_TX_OVER         3
`define BIT_TX_EMPTY        4
`define BIT_RD_REQ          5
`define BIT_TX_ABORT        6
`define BIT_RX_DONE         7
`define BIT_ACTIVITY        8
`define BIT_STOP_CONDITION_FLAG        9
`define BIT_START_CONDITION_FLAG       10
`define BIT_GEN_CALL        11
`define NUM_FLAGS           12

// Flags cleared by the combined clear (activity handled apart)
`define SW_CLEAR_MASK       16'h0eeb
// Abort source bits that survive a clearing read
`define ABORT_KEEP_MASK     16'h0200

// Reset values
`define RST_RAW_STATUS      16'h0000
`define RST_ABORT_SOURCE    16'h0000
`define RST_ON_OFF          1'b0

// Bus answers
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// File: i2c_irq_clear_on_read_bank.v
// Read-to-clear interrupt flag bank with raw status, abort source and enable
`timescale 1ns/1ps
`include "i2c_clear_bank_defines.vh"

module i2c_irq_clear_on_read_bank #(
  parameter FLAG_COUNT = `NUM_FLAGS
) (
  // Clock and reset
  input  wire                  clock,
  input  wire                  rst_n,
  // AXI4-Lite write address and data
  input  wire                  awvalid,
  output wire                  awready,
  input  wire [31:0]           awaddr,
  input  wire                  wvalid,
  output wire                  wready,
  input  wire [31:0]           wdata,
  input  wire [3:0]            wstrb,
  // AXI4-Lite write response
  output wire                  bvalid,
  input  wire                  bready,
  output wire [1:0]            bresp,
  // AXI4-Lite read
  input  wire                  arvalid,
  output wire                  arready,
  input  wire [31:0]           araddr,
  output wire                  rvalid,
  input  wire                  rready,
  output wire [31:0]           rdata,
  output wire [1:0]            rresp,
  // Events and levels from the bus engine
  input  wire [FLAG_COUNT-1:0] flagEvent,
  input  wire                  busActive,
  input  wire [15:0]           abortCauseSet,
  // Status and control towards the controller
  output reg  [15:0]           rawIrqStatus_q,
  output reg  [15:0]           abortSource_q,
  output reg                   ctrlEnable_q,
  output reg                   txFifoFlush_q,
  output reg                   rxFifoFlush_q
);

  wire        regRd;
  wire [31:0] regRdAddr;
  wire        regWr;
  wire [31:0] regWrAddr;
  wire [31:0] regWrData;
  wire [3:0]  regWrStrb;
  reg  [31:0] rdMux;
  reg         rdErr;
  reg         wrErr;
  reg  [15:0] clrVec;
  reg         activityClr;
  reg         abortClr;
  reg         txHold_q;
  reg         txHold_d;
  reg  [15:0] abortSource_d;
  reg         activity_d;
  wire [15:0] rawNext;

  // Bus slave front end
  axi_lite_port uPort (
    .clock     (clock),
    .rst_n     (rst_n),
    .awvalid   (awvalid),
    .awready   (awready),
    .awaddr    (awaddr),
    .wvalid    (wvalid),
    .wready    (wready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .bvalid    (bvalid),
    .bready    (bready),
    .bresp     (bresp),
    .arvalid   (arvalid),
    .arready   (arready),
    .araddr    (araddr),
    .rvalid    (rvalid),
    .rready    (rready),
    .rdata     (rdata),
    .rresp     (rresp),
    .regRd     (regRd),
    .regRdAddr (regRdAddr),
    .regRdData (rdMux),
    .regRdErr  (rdErr),
    .regWr     (regWr),
    .regWrAddr (regWrAddr),
    .regWrData (regWrData),
    .regWrStrb (regWrStrb),
    .regWrErr  (wrErr)
  );

  // Clear strobes, raised only by a read access
  always @* begin
    clrVec      = 16'h0000;
    activityClr = 1'b0;
    abortClr    = 1'b0;
    if (regRd) begin
      case (regRdAddr)
        `ADDR_COMBINED_CLR: begin
          clrVec      = `SW_CLEAR_MASK; // RQ14
          activityClr = 1'b1; // RQ14
          abortClr    = 1'b1; // RQ14
        end
        `ADDR_RX_UNDER_CLR: begin
          clrVec[`BIT_RX_UNDER] = 1'b1; // RQ15
        end
        `ADDR_RX_OVER_CLR: begin
          clrVec[`BIT_RX_OVER] = 1'b1; // RQ1
        end
        `ADDR_TX_OVER_CLR: begin
          clrVec[`BIT_TX_OVER] = 1'b1; // RQ2
        end
        `ADDR_RD_REQ_CLR: begin
          clrVec[`BIT_RD_REQ] = 1'b1; // RQ3
        end
        `ADDR_TX_ABORT_CLR: begin
          clrVec[`BIT_TX_ABORT] = 1'b1; // RQ4
          abortClr              = 1'b1; // RQ4
        end
        `ADDR_RX_DONE_CLR: begin
          clrVec[`BIT_RX_DONE] = 1'b1; // RQ7
        end
        `ADDR_ACTIVITY_CLR: begin
          activityClr = 1'b1; // RQ8
        end
        `ADDR_STOP_CONDITION_FLAG_CLR: begin
          clrVec[`BIT_STOP_CONDITION_FLAG] = 1'b1; // RQ17
        end
        `ADDR_START_CONDITION_FLAG_CLR: begin
          clrVec[`BIT_START_CONDITION_FLAG] = 1'b1; // RQ12
        end
        `ADDR_GEN_CALL_CLR: begin
          clrVec[`BIT_GEN_CALL] = 1'b1; // RQ13
        end
        default: begin
          clrVec = 16'h0000;
        end
      endcase
    end
  end

  // Read data; value shown is the flag before this read clears it
  always @* begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    case (regRdAddr)
      `ADDR_COMBINED_CLR:  rdMux[0] = |rawIrqStatus_q;
      `ADDR_RX_UNDER_CLR:  rdMux[0] = rawIrqStatus_q[`BIT_RX_UNDER];
      `ADDR_RX_OVER_CLR:   rdMux[0] = rawIrqStatus_q[`BIT_RX_OVER];
      `ADDR_TX_OVER_CLR:   rdMux[0] = rawIrqStatus_q[`BIT_TX_OVER];
      `ADDR_RD_REQ_CLR:    rdMux[0] = rawIrqStatus_q[`BIT_RD_REQ];
      `ADDR_TX_ABORT_CLR:  rdMux[0] = rawIrqStatus_q[`BIT_TX_ABORT];
      `ADDR_RX_DONE_CLR:   rdMux[0] = rawIrqStatus_q[`BIT_RX_DONE];
      `ADDR_ACTIVITY_CLR:  rdMux[0] = rawIrqStatus_q[`BIT_ACTIVITY]; // RQ11
      `ADDR_STOP_CONDITION_FLAG_CLR:  rdMux[0] = rawIrqStatus_q[`BIT_STOP_CONDITION_FLAG];
      `ADDR_START_CONDITION_FLAG_CLR: rdMux[0] = rawIrqStatus_q[`BIT_START_CONDITION_FLAG];
      `ADDR_GEN_CALL_CLR:  rdMux[0] = rawIrqStatus_q[`BIT_GEN_CALL]; // RQ18
      `ADDR_ON_OFF:        rdMux[0] = ctrlEnable_q;
      `ADDR_ABORT_SOURCE:  rdMux[15:0] = abortSource_q;
      `ADDR_RAW_STATUS:    rdMux[15:0] = rawIrqStatus_q;
      default:             rdErr = 1'b1;
    endcase
  end

  // Write decode: clear registers accept and ignore writes
  always @* begin
    case (regWrAddr)
      `ADDR_COMBINED_CLR, `ADDR_RX_UNDER_CLR, `ADDR_RX_OVER_CLR,
      `ADDR_TX_OVER_CLR, `ADDR_RD_REQ_CLR, `ADDR_TX_ABORT_CLR,
      `ADDR_RX_DONE_CLR, `ADDR_ACTIVITY_CLR, `ADDR_STOP_CONDITION_FLAG_CLR,
      `ADDR_START_CONDITION_FLAG_CLR, `ADDR_GEN_CALL_CLR, `ADDR_ON_OFF,
      `ADDR_ABORT_SOURCE, `ADDR_RAW_STATUS: wrErr = 1'b0; // RQ18
      default: wrErr = 1'b1;
    endcase
  end

  // Per-flag next value; an event in the clearing cycle wins
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : gFlag
      if (gi >= FLAG_COUNT) begin : gUnused
        assign rawNext[gi] = 1'b0;
      end else if (gi == `BIT_RX_FULL || gi == `BIT_TX_EMPTY) begin : gLevel
        // Hardware-cleared levels follow the engine directly
        assign rawNext[gi] = flagEvent[gi];
      end else if (gi == `BIT_ACTIVITY) begin : gAct
        assign rawNext[gi] = activity_d;
      end else begin : gSticky
        assign rawNext[gi] = flagEvent[gi] | (rawIrqStatus_q[gi] & ~clrVec[gi]);
      end
    end
  endgenerate

  // Activity: busy bus dominates any clear, idle+disabled self-clears
  always @* begin
    activity_d = busActive | flagEvent[`BIT_ACTIVITY]; // RQ9
    if (rawIrqStatus_q[`BIT_ACTIVITY] && !activityClr && ctrlEnable_q) begin
      activity_d = 1'b1; // RQ8
    end
    if (!ctrlEnable_q && !busActive) begin
      activity_d = flagEvent[`BIT_ACTIVITY]; // RQ10
    end
  end

  // Abort source: cleared by read except the kept bit; new causes win
  always @* begin
    abortSource_d = abortSource_q;
    if (abortClr) begin
      abortSource_d = abortSource_q & `ABORT_KEEP_MASK; // RQ6
    end
    if (!ctrlEnable_q) begin
      abortSource_d = abortSource_d & ~`ABORT_KEEP_MASK;
    end
    abortSource_d = abortSource_d | abortCauseSet;
  end

  // Transmit hold after abort, released by the clearing read
  always @* begin
    txHold_d = txHold_q;
    if (abortClr) begin
      txHold_d = 1'b0; // RQ5
    end
    if (flagEvent[`BIT_TX_ABORT]) begin
      txHold_d = 1'b1;
    end
  end

  // State registers
  always @(posedge clock) begin
    if (!rst_n) begin
      rawIrqStatus_q <= `RST_RAW_STATUS;
      abortSource_q  <= `RST_ABORT_SOURCE;
      ctrlEnable_q   <= `RST_ON_OFF;
      txHold_q       <= 1'b0;
    end else begin
      rawIrqStatus_q <= rawNext; // RQ1
      abortSource_q  <= abortSource_d; // RQ4
      txHold_q       <= txHold_d;
      if (regWr && regWrAddr == `ADDR_ON_OFF && regWrStrb[0]) begin
        ctrlEnable_q <= regWrData[0];
      end
    end
  end

  // FIFO flush controls; a disabled controller keeps both FIFOs flushed
  always @(posedge clock) begin
    if (!rst_n) begin
      txFifoFlush_q <= 1'b1;
      rxFifoFlush_q <= 1'b1;
    end else begin
      txFifoFlush_q <= ~ctrlEnable_q | txHold_d; // RQ16
      rxFifoFlush_q <= ~ctrlEnable_q; // RQ16
    end
  end

endmodule // i2c_irq_clear_on_read_bank

// File: i2c_irq_clear_on_read_bank_sva.sv
// Concurrent checks on the ports of the flag clear bank
`timescale 1ns/1ps
`include "i2c_clear_bank_defines.vh"

module i2c_irq_clear_on_read_bank_sva #(
  parameter FLAG_COUNT = `NUM_FLAGS
) (
  // Clock and reset
  input wire                  clock,
  input wire                  rst_n,
  // Read channel
  input wire                  arvalid,
  input wire                  arready,
  input wire [31:0]           araddr,
  input wire                  rvalid,
  input wire [31:0]           rdata,
  // Engine side and status
  input wire [FLAG_COUNT-1:0] flagEvent,
  input wire                  busActive,
  input wire [15:0]           abortCauseSet,
  input wire [15:0]           rawIrqStatus_q,
  input wire [15:0]           abortSource_q,
  input wire                  ctrlEnable_q,
  input wire                  txFifoFlush_q,
  input wire                  rxFifoFlush_q
);
  // Taken reads by target; quiet means no set event can race the clear
  wire takeOver  = arvalid && arready && araddr == `ADDR_RX_OVER_CLR;
  wire takeAbort = arvalid && arready && araddr == `ADDR_TX_ABORT_CLR;
  wire takeAct   = arvalid && arready && araddr == `ADDR_ACTIVITY_CLR;
  wire quietAbrt = !flagEvent[6] && abortCauseSet == 16'h0000;
  wire idle      = !busActive && !flagEvent[8];

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_over_clear: assert property (
    takeOver && !flagEvent[1] ##1 !flagEvent[1] |=> !rawIrqStatus_q[1])
    else $error("overflow flag survived its clearing read");
  a_abort_clear: assert property (
    takeAbort && quietAbrt ##1 quietAbrt |=> !rawIrqStatus_q[6] && (abortSource_q & 16'hfdff) == 0)
    else $error("abort flag or cause bits not cleared by read");
  a_cause_keep: assert property (
    takeAbort && quietAbrt && ctrlEnable_q ##1 quietAbrt && ctrlEnable_q
    |=> abortSource_q[9] == $past(abortSource_q[9], 2))
    else $error("abort cause bit 9 changed on clearing read");
  a_tx_release: assert property (
    takeAbort ##1 (ctrlEnable_q && !flagEvent[6]) [*3] |-> !txFifoFlush_q)
    else $error("transmit fifo still held after abort clear");
  a_fifo_flush: assert property (
    !ctrlEnable_q ##1 !ctrlEnable_q |-> txFifoFlush_q && rxFifoFlush_q)
    else $error("fifos not flushed while disabled");
  a_act_hold: assert property (
    busActive && rawIrqStatus_q[8] |=> rawIrqStatus_q[8])
    else $error("activity flag dropped while bus active");
  a_act_clear: assert property (
    takeAct && idle ##1 idle |=> !rawIrqStatus_q[8])
    else $error("activity flag not cleared by idle read");
  a_act_auto: assert property (
    (!ctrlEnable_q && idle) [*2] |=> !rawIrqStatus_q[8])
    else $error("activity flag not self cleared when disabled");
  a_act_read: assert property (
    takeAct |=> ##1 rvalid && rdata == {31'h0, $past(rawIrqStatus_q[8])})
    else $error("activity clear read data wrong");
  a_call_set: assert property (
    flagEvent[11] |=> rawIrqStatus_q[11])
    else $error("general call flag not latched");
endmodule // i2c_irq_clear_on_read_bank_sva

bind i2c_irq_clear_on_read_bank i2c_irq_clear_on_read_bank_sva #(
  .FLAG_COUNT(FLAG_COUNT)
) u_sva (
  .clock, .rst_n, .arvalid, .arready, .araddr, .rvalid, .rdata, .flagEvent, .busActive,
  .abortCauseSet, .rawIrqStatus_q, .abortSource_q, .ctrlEnable_q, .txFifoFlush_q,
  .rxFifoFlush_q
);

// File: i2c_irq_clear_on_read_bank_tb_top.sv
// Self-checking bench for the flag clear bank over AXI4-Lite
`timescale 1ns/1ps
`include "i2c_clear_bank_defines.vh"

module i2c_irq_clear_on_read_bank_tb_top;
  // Stimulus, observed ports and bookkeeping
  logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready, busActive;
  logic [31:0] awaddr, wdata, araddr, d;
  logic [3:0]  wstrb;
  logic [11:0] flagEvent, lvl;
  logic [15:0] abortCauseSet;
  logic [1:0]  r;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] rawIrqStatus_q, abortSource_q;
  wire         ctrlEnable_q, txFifoFlush_q, rxFifoFlush_q;
  int          errCount, comparisons, cycles;

  i2c_irq_clear_on_read_bank u_dut (
    .clock, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
    .rresp, .flagEvent, .busActive, .abortCauseSet, .rawIrqStatus_q, .abortSource_q,
    .ctrlEnable_q, .txFifoFlush_q, .rxFifoFlush_q
  );

  // Free running clock, 50 ns period
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end

  // Cycle ceiling, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errCount++;
      conclude;
    end
  end

  // Wide enough for a status flag joined to a full data word
  task check(input [63:0] seen, input [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task conclude;
    if (errCount == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Read: address held until taken, rready held until rvalid seen
  task rd(input [31:0] a);
    @(posedge clock);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask

  // Write: address and data released independently, then response
  task wr(input [31:0] a, input [31:0] v);
    bit ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clock);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= v;
    wstrb <= 4'hf;
    bready <= 1;
    while (!(ad && dd && bvalid)) begin
      @(posedge clock);
      if (!ad && awready) begin ad = 1; awvalid <= 0; end
      if (!dd && wready) begin dd = 1; wvalid <= 0; end
    end
    r = bresp;
    bready <= 0;
  endtask

  // One-cycle set pulses on top of the level bits
  task pulse(input [11:0] m, input [15:0] a);
    @(posedge clock);
    flagEvent <= lvl | m;
    abortCauseSet <= a;
    @(posedge clock);
    flagEvent <= lvl;
    abortCauseSet <= 16'h0000;
    @(posedge clock);
  endtask

  task tReset;
    for (int i = 0; i < 10; i++) begin
      rd(`ADDR_RX_OVER_CLR + 4 * i);
      check(d, 32'h0);
    end
    check(rawIrqStatus_q, 16'h0000);
    check({txFifoFlush_q, rxFifoFlush_q}, 2'h3);
    rd(32'h50001300);
    check({r, d}, {`RESP_SLVERR, 32'h0});
    wr(32'h50001300, 32'h1);
    check(r, `RESP_SLVERR);
  endtask

  // Every plain flag: write ignored, read returns and clears it
  task tSimple;
    int b [8] = '{0, 1, 3, 5, 7, 9, 10, 11};
    logic [31:0] a [8] = '{`ADDR_RX_UNDER_CLR, `ADDR_RX_OVER_CLR, `ADDR_TX_OVER_CLR,
      `ADDR_RD_REQ_CLR, `ADDR_RX_DONE_CLR, `ADDR_STOP_CONDITION_FLAG_CLR, `ADDR_START_CONDITION_FLAG_CLR,
      `ADDR_GEN_CALL_CLR};
    for (int i = 0; i < 8; i++) begin
      pulse(12'h001 << b[i], 16'h0000);
      wr(a[i], 32'h1);
      check(r, `RESP_OKAY);
      check(rawIrqStatus_q[b[i]], 1);
      rd(a[i]);
      check(d, 32'h1);
      check(rawIrqStatus_q[b[i]], 0);
      rd(a[i]);
      check(d, 32'h0);
    end
  endtask

  task tAbort;
    wr(`ADDR_ON_OFF, 32'h1);
    rd(`ADDR_ON_OFF);
    check({d, ctrlEnable_q, rxFifoFlush_q}, {32'h1, 1'b1, 1'b0});
    pulse(12'h040, 16'h0205);
    check({txFifoFlush_q, abortSource_q}, {1'b1, 16'h0205});
    rd(`ADDR_TX_ABORT_CLR);
    check(d, 32'h1);
    check({rawIrqStatus_q[6], abortSource_q}, {1'b0, 16'h0200});
    @(posedge clock);
    check(txFifoFlush_q, 0);
  endtask

  // Activity held while bus busy, cleared when idle or disabled
  task tActivity;
    busActive <= 1;
    pulse(12'h100, 16'h0000);
    rd(`ADDR_ACTIVITY_CLR);
    check(d, 32'h1);
    check(rawIrqStatus_q[8], 1);
    busActive <= 0;
    rd(`ADDR_ACTIVITY_CLR);
    check({d, rawIrqStatus_q[8]}, {32'h1, 1'b0});
    pulse(12'h100, 16'h0000);
    wr(`ADDR_ON_OFF, 32'h0);
    repeat (2) @(posedge clock);
    check(rawIrqStatus_q[8], 0);
    check({txFifoFlush_q, rxFifoFlush_q}, 2'h3);
  endtask

  // Combined clear keeps the level flag and cause bit 9
  task tCombined;
    wr(`ADDR_ON_OFF, 32'h1);
    lvl = 12'h004;
    pulse(12'hfeb, 16'h0201);
    rd(`ADDR_COMBINED_CLR);
    check(d, 32'h1);
    check({rawIrqStatus_q, abortSource_q}, {16'h0004, 16'h0200});
    rd(`ADDR_RAW_STATUS);
    check(d, 32'h4);
    rd(`ADDR_ABORT_SOURCE);
    check(d, 32'h200);
    lvl = 12'h000;
  endtask

  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, busActive} = 0;
    {awaddr, wdata, araddr, wstrb} = 0;
    flagEvent = 0;
    lvl = 0;
    abortCauseSet = 0;
    errCount = 0;
    comparisons = 0;
    cycles = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1;
    tReset;
    tSimple;
    tAbort;
    tActivity;
    tCombined;
    conclude;
  end
endmodule // i2c_irq_clear_on_read_bank_tb_top
